// *** inc/dpm_defs.vh ***
// Purpose: constants of the drive parameter-management block
// Assumes: parameter addresses are the fieldbus word addresses
// Notes: included by every design file of the block
`ifndef DPM_DEFS_VH
`define DPM_DEFS_VH

// parameter addresses
`define DPM_ADR_SAVE 16'h0402
`define DPM_ADR_RECALC 16'h040e
`define DPM_ADR_UDFLT 16'h0410
`define DPM_ADR_RESCALE 16'h0428
`define DPM_ADR_DIST 16'h2e14
`define DPM_ADR_RXBLK 16'h4084

// reset values
`define DPM_RST_DIST 32'h0000_4000
`define DPM_RST_RECALC 16'h0000
`define DPM_RST_RESCALE 16'h0000
`define DPM_RST_RXBLK 16'h0000

// value ranges
`define DPM_DIST_MAX 32'h7fff_ffff
`define DPM_RECALC_MAX 16'h0001
`define DPM_RESCALE_MAX 16'h0002
`define DPM_RXBLK_MAX 16'h0001
`define DPM_UDFLT_ALL 16'hffff

// command values and field positions
`define DPM_CMD_GO 16'h0001
`define DPM_SCL_IDLE 16'h0000
`define DPM_SCL_INIT 16'h0001
`define DPM_SCL_START 16'h0002
`define DPM_UDFLT_USER_BIT 0
`define DPM_UDFLT_SEQ_BIT 1
`define DPM_UDFLT_RSV_MSB 15
`define DPM_UDFLT_RSV_LSB 2

`endif

// *** logic/dpm_dist_mon.v ***
// Purpose: following-distance monitor of the drive
// Assumes: deviation is a signed position error in user units
// Notes: limit is latched only when a movement starts
`include "dpm_defs.vh"

module dpm_dist_mon (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // limit as stored by software
    input wire [31:0] limit_in,
    // motion status
    input wire move_start,
    input wire ref_active,
    input wire [31:0] deviation,
    // error handling
    input wire fault_clear,
    output reg [31:0] limit_active_r,
    output reg dist_err_r
);

////////////////////////////////////////////////////////////////////////////////
reg [32:0] dev_mag;
wire exceed;

always @*
begin
    // 33 bits so that the most negative deviation still has a magnitude
    if (deviation[31])
        dev_mag = 33'h0_0000_0000 - {deviation[31], deviation};
    else
        dev_mag = {1'b0, deviation};
end

// zero limit keeps the monitor silent
assign exceed = ref_active && (limit_active_r != 32'h0000_0000) &&
    (dev_mag > {1'b0, limit_active_r});

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk)
begin
    if (srst)
    begin
        limit_active_r <= `DPM_RST_DIST;
        dist_err_r <= 1'b0;
    end
    else
    begin
        if (move_start)
            limit_active_r <= limit_in;
        // a new excess wins over a clear in the same cycle
        if (exceed)
            dist_err_r <= 1'b1;
        else if (fault_clear)
            dist_err_r <= 1'b0;
    end
end

endmodule

// *** logic/dpm_regs.v ***
// Purpose: parameter-management register block of a servo drive
// Assumes: one parameter access at a time, inputs synchronous to sys_clk
// Notes: actions are pulses to the drive firmware side; no storage here
// Operation
// - With a reference value active, a deviation above the limit raises a class 1 error.
// - A limit of zero switches distance monitoring off.
// - The limit is signed 32-bit, default 16384, range 0 to 2147483647.
// - A new limit takes effect only at the start of the next movement.
// - Writing 1 to the loop recalc parameter recomputes the loop from motor data.
// - The loop recalculation leaves current and velocity limits alone.
// - Loop recalc and user defaults stay in working memory and are not saved.
// - Recalc, rescale and user-default writes are taken only with power stage off.
// - Rescaling is 1 to initialise then 2 to start; 0 is inactive.
// - Writing 1 to the save trigger saves persistent parameters.
// - The save trigger reads nonzero while saving and 0 once done.
// - User default bit 0 restores user and loop, bit 1 sequences, 65535 all.
// - User defaults spare communication, direction inversion and io functions.
// - Restored user defaults take effect at the next power stage enable.
// - Receive object block 1 ignores received objects, 0 processes them at once.
`include "dpm_defs.vh"

module dpm_regs (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // parameter access
    input wire par_wr,
    input wire par_rd,
    input wire [15:0] par_addr,
    input wire [31:0] par_wdata,
    output reg [31:0] par_rdata_r,
    output reg par_ack_r,
    output reg par_nak_r,
    // drive status
    input wire power_stage_en,
    input wire ref_active,
    input wire move_start,
    input wire [31:0] deviation,
    input wire fault_clear,
    // following error
    output wire dist_err,
    output wire [31:0] dist_limit_active,
    // loop recalculation
    output reg loop_recalc_req_r,
    input wire loop_recalc_done,
    // unit rescaling
    output reg rescale_init_r,
    output reg rescale_start_r,
    input wire rescale_done,
    // non-volatile save
    output reg nv_save_req_r,
    input wire nv_save_done,
    // user defaults
    output reg udflt_user_r,
    output reg udflt_seq_r,
    output reg udflt_apply_r,
    // receive process data
    output reg rx_obj_block_r
);

////////////////////////////////////////////////////////////////////////////////
// one-hot rescale states
localparam [2:0] SCL_IDLE = 3'b001;
localparam [2:0] SCL_INIT = 3'b010;
localparam [2:0] SCL_RUN = 3'b100;

reg [31:0] dist_limit_r;
reg [31:0] dist_limit_nxt;
reg recalc_busy_r;
reg save_busy_r;
reg udflt_pend_r;
reg pwr_prev_r;
reg [2:0] scl_state_r;
reg [2:0] scl_state_nxt;
reg wr_ok;
reg wr_legal;
reg [31:0] rd_val;
reg rd_hit;

wire wr_go;
wire pwr_rise;

// mapped-address check, used by read and write decode
function addr_known;
    input [15:0] a;
    begin
        case (a)
            `DPM_ADR_SAVE, `DPM_ADR_RECALC, `DPM_ADR_UDFLT,
            `DPM_ADR_RESCALE, `DPM_ADR_DIST, `DPM_ADR_RXBLK:
                addr_known = 1'b1;
            default:
                addr_known = 1'b0;
        endcase
    end
endfunction

// addresses that only accept writes with the power stage off
function needs_pwr_off;
    input [15:0] a;
    begin
        case (a)
            `DPM_ADR_RECALC, `DPM_ADR_UDFLT, `DPM_ADR_RESCALE:
                needs_pwr_off = 1'b1;
            default:
                needs_pwr_off = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// value range check per parameter
always @*
begin
    wr_legal = 1'b0;
    case (par_addr)
        `DPM_ADR_DIST:
            wr_legal = ~par_wdata[31];
        `DPM_ADR_RECALC:
            wr_legal = (par_wdata[31:16] == 16'h0000) &&
                (par_wdata[15:0] <= `DPM_RECALC_MAX);
        `DPM_ADR_RXBLK:
            wr_legal = (par_wdata[31:16] == 16'h0000) &&
                (par_wdata[15:0] <= `DPM_RXBLK_MAX);
        `DPM_ADR_SAVE:
            wr_legal = (par_wdata[31:0] == {16'h0000, `DPM_CMD_GO}) &&
                !save_busy_r;
        `DPM_ADR_UDFLT:
            // reserved bits must be all clear unless the full reset code is used
            wr_legal = (par_wdata[31:16] == 16'h0000) &&
                ((par_wdata[`DPM_UDFLT_RSV_MSB:`DPM_UDFLT_RSV_LSB] == 14'h0000) ||
                (par_wdata[15:0] == `DPM_UDFLT_ALL));
        `DPM_ADR_RESCALE:
            // 2 is only taken after 1, never from idle
            wr_legal = (par_wdata[31:16] == 16'h0000) &&
                ((par_wdata[15:0] == `DPM_SCL_IDLE) ||
                (par_wdata[15:0] == `DPM_SCL_INIT && scl_state_r != SCL_RUN) ||
                (par_wdata[15:0] == `DPM_SCL_START && scl_state_r == SCL_INIT));
        default:
            wr_legal = 1'b0;
    endcase
    wr_ok = par_wr && addr_known(par_addr) && wr_legal &&
        !(needs_pwr_off(par_addr) && power_stage_en);
end

assign wr_go = wr_ok;
assign pwr_rise = power_stage_en && !pwr_prev_r;

////////////////////////////////////////////////////////////////////////////////
// readback mux
always @*
begin
    rd_hit = addr_known(par_addr);
    case (par_addr)
        `DPM_ADR_DIST:
            rd_val = dist_limit_r;
        `DPM_ADR_RECALC:
            rd_val = {31'h0000_0000, recalc_busy_r};
        `DPM_ADR_SAVE:
            rd_val = {31'h0000_0000, save_busy_r};
        `DPM_ADR_UDFLT:
            rd_val = 32'h0000_0000;
        `DPM_ADR_RESCALE:
            rd_val = (scl_state_r == SCL_INIT) ? {16'h0000, `DPM_SCL_INIT} :
                (scl_state_r == SCL_RUN) ? {16'h0000, `DPM_SCL_START} :
                32'h0000_0000;
        `DPM_ADR_RXBLK:
            rd_val = {31'h0000_0000, rx_obj_block_r};
        default:
            rd_val = 32'h0000_0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// next value of the stored limit
always @*
begin
    dist_limit_nxt = dist_limit_r;
    if (wr_go && par_addr == `DPM_ADR_DIST)
        dist_limit_nxt = par_wdata;
end

// rescale sequence
always @*
begin
    scl_state_nxt = scl_state_r;
    case (scl_state_r)
        SCL_IDLE:
        begin
            if (wr_go && par_addr == `DPM_ADR_RESCALE &&
                par_wdata[15:0] == `DPM_SCL_INIT)
                scl_state_nxt = SCL_INIT;
        end
        SCL_INIT:
        begin
            if (wr_go && par_addr == `DPM_ADR_RESCALE)
            begin
                if (par_wdata[15:0] == `DPM_SCL_START)
                    scl_state_nxt = SCL_RUN;
                else if (par_wdata[15:0] == `DPM_SCL_IDLE)
                    scl_state_nxt = SCL_IDLE;
            end
        end
        SCL_RUN:
        begin
            // the calculation finishes by itself; 0 may also abandon it
            if (rescale_done)
                scl_state_nxt = SCL_IDLE;
            else if (wr_go && par_addr == `DPM_ADR_RESCALE)
                scl_state_nxt = SCL_IDLE;
        end
        default:
            scl_state_nxt = SCL_IDLE;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// access answer and stored parameters
always @(posedge sys_clk)
begin
    if (srst)
    begin
        par_rdata_r <= 32'h0000_0000;
        par_ack_r <= 1'b0;
        par_nak_r <= 1'b0;
        dist_limit_r <= `DPM_RST_DIST;
        rx_obj_block_r <= 1'b0;
        scl_state_r <= SCL_IDLE;
        pwr_prev_r <= 1'b0;
    end
    else
    begin
        par_ack_r <= (par_rd && rd_hit) || wr_go;
        par_nak_r <= (par_rd && !rd_hit) || (par_wr && !wr_go);
        if (par_rd)
            par_rdata_r <= rd_val;
        dist_limit_r <= dist_limit_nxt;
        if (wr_go && par_addr == `DPM_ADR_RXBLK)
            rx_obj_block_r <= par_wdata[0];
        scl_state_r <= scl_state_nxt;
        pwr_prev_r <= power_stage_en;
    end
end

////////////////////////////////////////////////////////////////////////////////
// action pulses and busy flags
always @(posedge sys_clk)
begin
    if (srst)
    begin
        loop_recalc_req_r <= 1'b0;
        recalc_busy_r <= 1'b0;
        rescale_init_r <= 1'b0;
        rescale_start_r <= 1'b0;
        nv_save_req_r <= 1'b0;
        save_busy_r <= 1'b0;
        udflt_user_r <= 1'b0;
        udflt_seq_r <= 1'b0;
        udflt_pend_r <= 1'b0;
        udflt_apply_r <= 1'b0;
    end
    else
    begin
        // loop recalc touches loop gains only, never the limits
        loop_recalc_req_r <= wr_go && par_addr == `DPM_ADR_RECALC &&
            par_wdata[0];
        if (wr_go && par_addr == `DPM_ADR_RECALC && par_wdata[0])
            recalc_busy_r <= 1'b1;
        else if (loop_recalc_done)
            recalc_busy_r <= 1'b0;
        // every accepted 1 initialises again, also from the init state
        rescale_init_r <= wr_go && par_addr == `DPM_ADR_RESCALE &&
            par_wdata[15:0] == `DPM_SCL_INIT;
        rescale_start_r <= scl_state_r == SCL_INIT &&
            scl_state_nxt == SCL_RUN;
        // only this write ever reaches the non-volatile store
        nv_save_req_r <= wr_go && par_addr == `DPM_ADR_SAVE;
        if (wr_go && par_addr == `DPM_ADR_SAVE)
            save_busy_r <= 1'b1;
        else if (nv_save_done)
            save_busy_r <= 1'b0;
        // comms, direction inversion and io functions have no reset path here
        udflt_user_r <= wr_go && par_addr == `DPM_ADR_UDFLT &&
            par_wdata[`DPM_UDFLT_USER_BIT];
        udflt_seq_r <= wr_go && par_addr == `DPM_ADR_UDFLT &&
            par_wdata[`DPM_UDFLT_SEQ_BIT];
        // restored values are held back until the stage is enabled again
        if (wr_go && par_addr == `DPM_ADR_UDFLT &&
            par_wdata[`DPM_UDFLT_SEQ_BIT:`DPM_UDFLT_USER_BIT] != 2'b00)
            udflt_pend_r <= 1'b1;
        else if (pwr_rise)
            udflt_pend_r <= 1'b0;
        udflt_apply_r <= pwr_rise && udflt_pend_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// following-distance monitor
dpm_dist_mon u_dist_mon (
    .sys_clk(sys_clk),
    .srst(srst),
    .limit_in(dist_limit_r),
    .move_start(move_start),
    .ref_active(ref_active),
    .deviation(deviation),
    .fault_clear(fault_clear),
    .limit_active_r(dist_limit_active),
    .dist_err_r(dist_err)
);

endmodule

// *** bench/dpm_fw_model.sv ***
// Purpose: firmware side that answers the block's action requests
// Assumes: a request is a one-cycle pulse
// Notes: done comes about dly cycles later; dly of 0 never answers
module dpm_fw_model (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // handshake
    input wire req,
    input wire [3:0] dly,
    output reg done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] cnt_r;
    //////////////////////////////
    always @(posedge sys_clk)
    begin
        if (srst || req)
            cnt_r <= srst ? 4'h0 : dly;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        // late answer keeps the busy readback visible to polling
        done <= !srst && cnt_r == 4'h1;
    end
endmodule

// *** bench/dpm_regs_asserts.sv ***
// Purpose: port assertions of the parameter block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every dpm_regs
module dpm_regs_chk (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // access
    input wire par_wr,
    input wire par_rd,
    input wire [15:0] par_addr,
    input wire [31:0] par_wdata,
    input wire par_ack_r,
    input wire par_nak_r,
    // status
    input wire power_stage_en,
    input wire ref_active,
    input wire move_start,
    input wire [31:0] deviation,
    input wire dist_err,
    input wire [31:0] dist_limit_active,
    // actions
    input wire loop_recalc_req_r,
    input wire rescale_init_r,
    input wire nv_save_req_r,
    input wire udflt_user_r,
    input wire rx_obj_block_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence pwr_s(a); par_wr && power_stage_en && par_addr == a; endsequence
    sequence cmd_s(a); par_wr && par_addr == a && par_wdata == 32'h1; endsequence
    //////////////////////////////
    ack_once_a: assert property ((par_wr || par_rd) |=> par_ack_r != par_nak_r)
        else $error("access not answered once");
    pwr_refuse_a: assert property ((pwr_s(16'h040e) or pwr_s(16'h0410) or pwr_s(16'h0428))
        |=> par_nak_r)
        else $error("write taken with power stage on");
    limit_hold_a: assert property (!move_start |=> $stable(dist_limit_active))
        else $error("limit changed without movement");
    err_set_a: assert property (ref_active && dist_limit_active != 32'h0 &&
        ($signed(deviation) > $signed(dist_limit_active) ||
        -$signed(deviation) > $signed(dist_limit_active)) |=> dist_err)
        else $error("distance error missed");
    zero_off_a: assert property (!dist_err && dist_limit_active == 32'h0 |=> !dist_err)
        else $error("error with monitoring off");
    save_req_a: assert property (cmd_s(16'h0402) |=> par_nak_r != nv_save_req_r)
        else $error("save not started");
    resc_init_a: assert property (cmd_s(16'h0428) |=> par_nak_r != rescale_init_r)
        else $error("rescale init missing");
    rx_mask_a: assert property (par_wr && par_addr == 16'h4084 && par_wdata < 32'h2
        |=> rx_obj_block_r == $past(par_wdata[0]))
        else $error("receive block wrong");
    no_save_a: assert property (loop_recalc_req_r || udflt_user_r |-> !nv_save_req_r)
        else $error("reset saved to memory");
endmodule
bind dpm_regs dpm_regs_chk u_chk (.sys_clk, .srst, .par_wr, .par_rd, .par_addr, .par_wdata,
    .par_ack_r, .par_nak_r, .power_stage_en, .ref_active, .move_start, .deviation, .dist_err,
    .dist_limit_active, .loop_recalc_req_r, .rescale_init_r, .nv_save_req_r, .udflt_user_r,
    .rx_obj_block_r);

// *** bench/tb.sv ***
// Purpose: self-checking bench of the parameter block
// Assumes: inputs change at the falling edge
// Notes: expected answers queue up, a watcher pops them
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, srst = 1, par_wr = 0, par_rd = 0, power_stage_en = 0;
    logic ref_active = 0, move_start = 0, fault_clear = 0;
    logic [15:0] par_addr = 16'h0;
    logic [31:0] par_wdata = 32'h0, deviation = 32'h0, d;
    logic [3:0] dly = 4'h6;
    wire [31:0] par_rdata_r, dist_limit_active;
    wire par_ack_r, par_nak_r, dist_err, loop_recalc_req_r, loop_recalc_done, rescale_init_r;
    wire rescale_start_r, rescale_done, nv_save_req_r, nv_save_done, udflt_user_r;
    wire udflt_seq_r, udflt_apply_r, rx_obj_block_r;
    integer error_cnt = 0, comparisons = 0, seed = 89, pc = 0;
    logic [33:0] note_q[$];
    logic [33:0] n;
    logic [15:0] ra[6] = '{16'h2e14, 16'h040e, 16'h0410, 16'h0428, 16'h4084, 16'h0402};
    dpm_regs DUT (.sys_clk, .srst, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata_r,
        .par_ack_r, .par_nak_r, .power_stage_en, .ref_active, .move_start, .deviation,
        .fault_clear, .dist_err, .dist_limit_active, .loop_recalc_req_r, .loop_recalc_done,
        .rescale_init_r, .rescale_start_r, .rescale_done, .nv_save_req_r, .nv_save_done,
        .udflt_user_r, .udflt_seq_r, .udflt_apply_r, .rx_obj_block_r);
    dpm_fw_model u_lp (.sys_clk, .srst, .req(loop_recalc_req_r), .dly, .done(loop_recalc_done));
    dpm_fw_model u_sc (.sys_clk, .srst, .req(rescale_start_r), .dly, .done(rescale_done));
    dpm_fw_model u_nv (.sys_clk, .srst, .req(nv_save_req_r), .dly, .done(nv_save_done));
    //////////////////////////////
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, v);
        end
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic nk,
        input logic [31:0] e);
        note_q.push_back({nk, !w, e});
        par_wr = w;
        par_rd = !w;
        par_addr = a;
        par_wdata = wd;
        @(negedge sys_clk);
        par_wr = 0;
        par_rd = 0;
        @(negedge sys_clk);
    endtask
    task wr(input logic [15:0] a, input logic [31:0] wd, input logic nk);
        acc(1, a, wd, nk, 32'h0);
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e);
        acc(0, a, 32'h0, 0, e);
    endtask
    task mv;
        move_start = 1;
        @(negedge sys_clk);
        move_start = 0;
        @(negedge sys_clk);
    endtask
    task summarize;
        chk("left", 32'h0, note_q.size());
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    //////////////////////////////
    initial
        forever #5 sys_clk = ~sys_clk;
    // user, seq and apply pulses add 1, 2 and 4, summed off the launching edge to avoid a race
    always @(negedge sys_clk)
        pc = pc + {udflt_apply_r, udflt_seq_r, udflt_user_r};
    always @(negedge sys_clk)
        if (par_ack_r || par_nak_r)
        begin
            chk("pending", 32'h1, note_q.size() > 0);
            n = note_q.pop_front();
            chk("nak", n[33], par_nak_r);
            if (n[32] && par_ack_r)
                chk("rdata", n[31:0], par_rdata_r);
        end
    initial
    begin
        #20000;
        error_cnt++;
        summarize;
    end
    initial
    begin
        repeat (8) @(negedge sys_clk);
        srst = 0;
        @(negedge sys_clk);
        for (int i = 0; i < 6; i++)
            rd(ra[i], i == 0 ? 32'h4000 : 32'h0);
        acc(0, 16'h0001, 32'h0, 1, 32'h0);
        d = $random(seed) & 32'h7fff_ffff;
        wr(16'h2e14, d, 0);
        rd(16'h2e14, d);
        wr(16'h2e14, 32'h8000_0000, 1);
        chk("limit", 32'h4000, dist_limit_active);
        mv;
        chk("limit", d, dist_limit_active);
        wr(16'h2e14, 32'h64, 0);
        mv;
        ref_active = 1;
        deviation = 32'h64;
        @(negedge sys_clk);
        chk("err", 32'h0, dist_err);
        deviation = -32'sd101;
        @(negedge sys_clk);
        chk("err", 32'h1, dist_err);
        fault_clear = 1;
        deviation = 32'h0;
        @(negedge sys_clk);
        fault_clear = 0;
        wr(16'h2e14, 32'h0, 0);
        mv;
        deviation = 32'h7000_0000;
        repeat (3) @(negedge sys_clk);
        chk("err", 32'h0, dist_err);
        ref_active = 0;
        power_stage_en = 1;
        for (int i = 1; i < 4; i++)
            wr(ra[i], 32'h1, 1);
        power_stage_en = 0;
        wr(16'h040e, 32'h1, 0);
        rd(16'h040e, 32'h1);
        repeat (8) @(negedge sys_clk);
        rd(16'h040e, 32'h0);
        wr(16'h0428, 32'h2, 1);
        wr(16'h0428, 32'h1, 0);
        rd(16'h0428, 32'h1);
        wr(16'h0428, 32'h2, 0);
        rd(16'h0428, 32'h2);
        repeat (8) @(negedge sys_clk);
        rd(16'h0428, 32'h0);
        wr(16'h0402, 32'h1, 0);
        rd(16'h0402, 32'h1);
        wr(16'h0402, 32'h1, 1);
        repeat (8) @(negedge sys_clk);
        rd(16'h0402, 32'h0);
        wr(16'h0410, 32'h4, 1);
        wr(16'h0410, 32'hffff, 0);
        power_stage_en = 1;
        repeat (4) @(negedge sys_clk);
        chk("udflt", 32'h7, pc);
        wr(16'h4084, 32'h1, 0);
        chk("block", 32'h1, rx_obj_block_r);
        wr(16'h4084, 32'h1_0001, 1);
        rd(16'h4084, 32'h1);
        wr(16'h4084, 32'h0, 0);
        chk("block", 32'h0, rx_obj_block_r);
        // reset in mid-run must bring the default limit back
        srst = 1;
        repeat (2) @(negedge sys_clk);
        srst = 0;
        @(negedge sys_clk);
        chk("limit", 32'h4000, dist_limit_active);
        rd(16'h2e14, 32'h4000);
        summarize;
    end
endmodule
